// ### bench/three_wire_serial_port_pin_control_bench.sv
`timescale 1ns/1ps
`include "tsp_consts.svh"
module three_wire_serial_port_pin_control_bench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err, flip;
    logic watchdog_stack_reset, ce_reset, clock_stop, halt;
    logic [7:0] paddr, tx, rx;
    logic [31:0] pwdata, prdata, q;
    logic ck_o, ck_oe, so_o, so_oe, si_o, si_oe, sck, so, si;
    logic ck_en, si_en, run, load, p_ck, p_si;
    int miscompares, comparisons;

    // Pull-up on the clock line; other undriven lines toggle
    assign sck = ck_oe ? ck_o : (ck_en ? p_ck : 1'b1);
    assign so = so_oe ? so_o : flip;
    assign si = si_oe ? si_o : (si_en ? p_si : flip);

    // Block and far-side peer
    tsp_serial_port #(.HALF_CYCLES(8)) tsp_serial_port_i (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .watchdog_stack_reset, .ce_reset, .clock_stop, .halt, .irq,
        .shift_clock_pin_in(sck), .shift_clock_pin_out(ck_o), .shift_clock_pin_oe(ck_oe),
        .serial_out_pin_in(so), .serial_out_pin_out(so_o), .serial_out_pin_oe(so_oe),
        .serial_in_pin_in(si), .serial_in_pin_out(si_o), .serial_in_pin_oe(si_oe));
    tsp_peer tsp_peer_i (.sck(sck), .so(so), .run(run), .load(load), .tx_byte(tx),
        .ck_out(p_ck), .si_out(p_si), .rx_byte(rx));

    // Clock and toggling pattern
    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    always @(posedge pclk)
        flip <= ~flip;

    task summarize;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : summarize

    task timeout(input string nm);
        miscompares++;
        $display("FAIL %s expected done seen timeout", nm);
        summarize();
    endtask : timeout

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // One APB transfer; holds the request until pready is seen
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
            timeout("pready");
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        @(posedge pclk);
    endtask : wr

    task rd(input logic [7:0] a, input string nm, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, q);
    endtask : rd

    task cnt(input logic [3:0] e);
        apb(1'b0, `TSP_OFF_PINS, 32'h0);
        chk("count", e, q[6:3]);
    endtask : cnt

    task arm(input logic [7:0] b);
        tx <= b;
        load <= 1'b1;
        @(posedge pclk);
        load <= 1'b0;
    endtask : arm

    task wait_irq;
        int n;
        for (n = 0; irq !== 1'b1 && n < 600; n++)
            @(posedge pclk);
        if (n >= 600)
            timeout("irq");
    endtask : wait_irq

    task t_pins;
        chk("oe reset", 3'h0, {ck_oe, so_oe, si_oe});
        wr(`TSP_OFF_LATCH, 32'h1);
        wr(`TSP_OFF_DIR, 32'h7);
        chk("si drive", 2'h3, {si_oe, si_o});
        chk("so latch", 2'h2, {so_oe, so_o});
        for (int s = 0; s < 4; s++)
        begin
            wr(`TSP_OFF_CTRL, s);
            chk("clock wait", {1'b1, s != 0}, {ck_oe, ck_o});
        end
        halt <= 1'b1;
        repeat (4) @(posedge pclk);
        chk("halt pins", 4'hF, {ck_oe, so_oe, si_oe, ck_o});
        halt <= 1'b0;
        wr(`TSP_OFF_DIR, 32'h0);
        chk("float", 3'h0, {ck_oe, so_oe, si_oe});
        rd(8'h1C, "unmapped", 32'h0);
        chk("unmapped err", 1'b1, err);
        $display("pins done");
    endtask : t_pins

    task t_master;
        wr(`TSP_OFF_MASK, 32'h1);
        wr(`TSP_OFF_DIR, 32'h6);
        wr(`TSP_OFF_DATA, 32'hA5);
        si_en <= 1'b1;
        arm(8'h3C);
        wr(`TSP_OFF_CTRL, 32'hE);
        wait_irq();
        chk("peer rx", 8'hA5, rx);
        rd(`TSP_OFF_DATA, "data in", 32'h3C);
        cnt(4'h8);
        chk("clock high", 2'h3, {ck_oe, ck_o});
        rd(`TSP_OFF_CTRL, "wait", 32'hA);
        rd(`TSP_OFF_STAT, "status", 32'h1);
        @(posedge pclk);
        chk("irq clear", 1'b0, irq);
        $display("master done");
    endtask : t_master

    task t_slave_halt;
        halt <= 1'b1;
        wr(`TSP_OFF_DIR, 32'h2);
        ck_en <= 1'b1;
        wr(`TSP_OFF_DATA, 32'h96);
        arm(8'h69);
        wr(`TSP_OFF_CTRL, 32'hC);
        run <= 1'b1;
        @(posedge pclk);
        run <= 1'b0;
        wait_irq();
        chk("slave rx", 8'h96, rx);
        rd(`TSP_OFF_DATA, "slave data", 32'h69);
        chk("slave clock", 1'b0, ck_oe);
        rd(`TSP_OFF_STAT, "slave status", 32'h1);
        halt <= 1'b0;
        ck_en <= 1'b0;
        $display("slave done");
    endtask : t_slave_halt

    task t_master_halt;
        int n;
        wr(`TSP_OFF_CTRL, 32'hA); // Master wait first, so the clock pin stays high
        wr(`TSP_OFF_DIR, 32'h6);
        wr(`TSP_OFF_DATA, 32'h5A);
        halt <= 1'b1;
        wr(`TSP_OFF_CTRL, 32'hE);
        repeat (40) @(posedge pclk);
        chk("halted clock", 2'h3, {ck_oe, ck_o});
        cnt(4'h0);
        rd(`TSP_OFF_DATA, "halt data", 32'h5A);
        halt <= 1'b0;
        n = 0;
        do
        begin
            apb(1'b0, `TSP_OFF_PINS, 32'h0);
            n++;
        end
        while (q[6:3] < 3 && n < 100);
        if (n >= 100)
            timeout("count");
        wr(`TSP_OFF_CTRL, 32'hA);
        cnt(4'h0);
        rd(`TSP_OFF_CTRL, "forced", 32'hA);
        chk("forced clock", 2'h3, {ck_oe, ck_o});
        $display("master halt done");
    endtask : t_master_halt

    task t_resets;
        wr(`TSP_OFF_LATCH, 32'h2);
        wr(`TSP_OFF_DIR, 32'h7);
        for (int k = 0; k < 3; k++)
        begin
            wr(`TSP_OFF_CTRL, 32'hE);
            ce_reset <= (k == 0);
            clock_stop <= (k == 1);
            watchdog_stack_reset <= (k == 2);
            @(posedge pclk);
            {ce_reset, clock_stop, watchdog_stack_reset} <= 3'h0;
            @(posedge pclk);
            chk("so pin", (k < 2) ? 2'h3 : 2'h1, {so_oe, so_o});
            chk("oe", (k < 2) ? 3'h7 : 3'h0, {ck_oe, so_oe, si_oe});
            rd(`TSP_OFF_DIR, "dir", (k < 2) ? 32'h7 : 32'h0);
            rd(`TSP_OFF_CTRL, "ctrl", 32'h0);
        end
        $display("resets done");
    endtask : t_resets

    // Main sequence
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata, tx, flip} = '0;
        {watchdog_stack_reset, ce_reset, clock_stop, halt} = 4'h0;
        {ck_en, si_en, run, load, miscompares, comparisons} = '0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_pins();
        t_master();
        t_slave_halt();
        t_master_halt();
        t_resets();
        summarize();
    end
endmodule : three_wire_serial_port_pin_control_bench

// ### bench/tsp_peer.sv
`timescale 1ns/1ps
module tsp_peer (
    // Resolved pins
    input wire logic sck,
    input wire logic so,
    // Bench control
    input wire logic run,
    input wire logic load,
    input wire logic [7:0] tx_byte,
    // Pin drive
    output logic ck_out,
    output logic si_out,
    // Received byte
    output logic [7:0] rx_byte
);
    logic [7:0] tx_r;

    // Frame clock: idle high, eight 80 ns periods per run pulse, odd phase
    initial
    begin
        ck_out = 1'b1;
        si_out = 1'b0;
    end
    always @(posedge run)
    begin
        #3;
        repeat (8)
        begin
            ck_out = 1'b0;
            #40;
            ck_out = 1'b1;
            #40;
        end
    end

    // Load the byte to send
    always @(posedge load)
        tx_r = tx_byte;

    // Send MSB first on falls, receive on rises
    always @(negedge sck)
    begin
        si_out <= tx_r[7];
        tx_r <= {tx_r[6:0], 1'b0};
    end
    always @(posedge sck)
        rx_byte <= {rx_byte[6:0], so};
endmodule : tsp_peer

// ### verilog/tsp_consts.svh
`ifndef TSP_CONSTS_SVH
`define TSP_CONSTS_SVH

// Register byte offsets
`define TSP_OFF_CTRL 8'h00
`define TSP_OFF_DIR 8'h04
`define TSP_OFF_LATCH 8'h08
`define TSP_OFF_DATA 8'h0C
`define TSP_OFF_STAT 8'h10
`define TSP_OFF_MASK 8'h14
`define TSP_OFF_PINS 8'h18

// Control register fields
`define TSP_CTRL_SEL_LO 0
`define TSP_CTRL_SEL_HI 1
`define TSP_CTRL_TS 2
`define TSP_CTRL_OE 3

// Direction and latch fields
`define TSP_PIN_SI 0
`define TSP_PIN_SO 1
`define TSP_PIN_CK 2

// Reset values
`define TSP_CTRL_RST 4'h0
`define TSP_DIR_RST 3'h0
`define TSP_LATCH_RST 3'h0
`define TSP_MASK_RST 1'h0

// Transfer length and internal shift clock timing
`define TSP_BITS_PER_XFER 4'h8
`define TSP_PCLK_NS 8
`define TSP_SCK_HALF_NS 40
`define TSP_SCK_HALF_CYC (`TSP_SCK_HALF_NS / `TSP_PCLK_NS)

`endif

// ### verilog/tsp_pkg.sv
package tsp_pkg;

    // Wait control state of the port
    typedef enum logic {TSP_WAIT, TSP_RUN} tsp_xfer_t;

endpackage : tsp_pkg

// ### verilog/tsp_serial_port.sv
`timescale 1ns/1ps
`include "tsp_consts.svh"
// Behaviour
// - clock select zero is slave, else master
// - serial-in direction 0 floats the pin
// - serial-in direction 1 drives port latch
// - serial-out latch or float when output disabled
// - count rising shift clock pin edges while running
// - output enabled shifts MSB out on falls
// - rising edge samples serial-in into LSB
// - power-on, watchdog reset make pins inputs
// - chip-enable, clock stop keep pin directions
// - halt keeps every pin configuration
// - halt stops internal shift clock output
// - halt lets external clock keep shifting
// - halt leaves master shift register untouched
// - eight clocks then wait, counter holds eight
// - interrupt at rising edge counting eight
// - writing zero forces wait, clears counter
// - master waiting holds clock pin high
module tsp_serial_port
    import tsp_pkg::*;
#(
    parameter int HALF_CYCLES = `TSP_SCK_HALF_CYC
)
(
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // System events, same clock domain
    input wire logic watchdog_stack_reset,
    input wire logic ce_reset,
    input wire logic clock_stop,
    input wire logic halt,
    // Shift clock pin
    input wire logic shift_clock_pin_in,
    output logic shift_clock_pin_out,
    output logic shift_clock_pin_oe,
    // Serial out pin
    input wire logic serial_out_pin_in,
    output logic serial_out_pin_out,
    output logic serial_out_pin_oe,
    // Serial in pin
    input wire logic serial_in_pin_in,
    output logic serial_in_pin_out,
    output logic serial_in_pin_oe,
    // Interrupt
    output logic irq
);

    logic [1:0] clock_select_r;
    logic serial_output_enable_r;
    tsp_xfer_t xfer_r;
    logic [2:0] pin_dir_r;
    logic [2:0] port_latch_r;
    logic [7:0] serial_shift_register_r;
    logic [3:0] clk_count_r;
    logic so_bit_r;
    logic irq_stat_r;
    logic irq_mask_r;
    logic gen_clk_r;
    logic [15:0] div_r;
    logic [2:0] ck_sync_r;
    logic [1:0] si_sync_r;
    logic [1:0] so_sync_r;
    logic [31:0] prdata_r;

    logic master;
    logic running;
    logic ck_rise;
    logic ck_fall;
    logic setup_ph;
    logic wr_acc;
    logic rd_acc;
    logic mapped;
    logic ctrl_wr;
    logic port_reset;
    logic last_rise;
    logic [15:0] div_last;

    assign div_last = 16'(HALF_CYCLES - 1);
    assign master = (clock_select_r != 2'h0);
    assign running = (xfer_r == TSP_RUN);
    assign port_reset = ce_reset | clock_stop;

    // APB decode
    assign setup_ph = psel & ~penable;
    assign wr_acc = psel & penable & pwrite;
    assign rd_acc = psel & penable & ~pwrite;
    assign pready = 1'b1;
    always_comb
    begin
        if (paddr == `TSP_OFF_CTRL) mapped = 1'b1;
        else if (paddr == `TSP_OFF_DIR) mapped = 1'b1;
        else if (paddr == `TSP_OFF_LATCH) mapped = 1'b1;
        else if (paddr == `TSP_OFF_DATA) mapped = 1'b1;
        else if (paddr == `TSP_OFF_STAT) mapped = 1'b1;
        else if (paddr == `TSP_OFF_MASK) mapped = 1'b1;
        else if (paddr == `TSP_OFF_PINS) mapped = 1'b1;
        else mapped = 1'b0;
    end
    assign pslverr = psel & penable & ~mapped;
    assign ctrl_wr = wr_acc & (paddr == `TSP_OFF_CTRL);
    assign prdata = prdata_r;

    // Read data captured in the setup phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_r <= 32'h0;
        else if (setup_ph & ~pwrite)
        begin
            if (paddr == `TSP_OFF_CTRL)
                prdata_r <= {28'h0, serial_output_enable_r, running, clock_select_r};
            else if (paddr == `TSP_OFF_DIR)
                prdata_r <= {29'h0, pin_dir_r};
            else if (paddr == `TSP_OFF_LATCH)
                prdata_r <= {29'h0, port_latch_r};
            else if (paddr == `TSP_OFF_DATA)
                prdata_r <= {24'h0, serial_shift_register_r};
            else if (paddr == `TSP_OFF_STAT)
                prdata_r <= {31'h0, irq_stat_r};
            else if (paddr == `TSP_OFF_MASK)
                prdata_r <= {31'h0, irq_mask_r};
            else if (paddr == `TSP_OFF_PINS)
                prdata_r <= {25'h0, clk_count_r, ck_sync_r[1], so_sync_r[1], si_sync_r[1]};
            else
                prdata_r <= 32'h0;
        end
    end

    // Pin synchronisers; third clock stage only for edge detection
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ck_sync_r <= 3'h7;
            si_sync_r <= 2'h0;
            so_sync_r <= 2'h0;
        end
        else
        begin
            ck_sync_r <= {ck_sync_r[1:0], shift_clock_pin_in};
            si_sync_r <= {si_sync_r[0], serial_in_pin_in};
            so_sync_r <= {so_sync_r[0], serial_out_pin_in};
        end
    end
    assign ck_rise = ck_sync_r[1] & ~ck_sync_r[2];
    assign ck_fall = ~ck_sync_r[1] & ck_sync_r[2];
    assign last_rise = running & ck_rise & (clk_count_r == `TSP_BITS_PER_XFER - 4'h1);

    // Mode and output enable; chip-enable reset and clock stop drop serial use
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            clock_select_r <= 2'(`TSP_CTRL_RST);
            serial_output_enable_r <= 1'b0;
        end
        else if (watchdog_stack_reset | port_reset)
        begin
            clock_select_r <= 2'h0;
            serial_output_enable_r <= 1'b0;
        end
        else if (ctrl_wr)
        begin
            clock_select_r <= {pwdata[`TSP_CTRL_SEL_HI], pwdata[`TSP_CTRL_SEL_LO]};
            serial_output_enable_r <= pwdata[`TSP_CTRL_OE];
        end
    end

    // Pin directions; only power-on and watchdog reset return them to input
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pin_dir_r <= `TSP_DIR_RST;
        else if (watchdog_stack_reset)
            pin_dir_r <= `TSP_DIR_RST;
        else if (wr_acc & (paddr == `TSP_OFF_DIR))
            pin_dir_r <= pwdata[2:0];
    end

    // Port output latch
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            port_latch_r <= `TSP_LATCH_RST;
        else if (wr_acc & (paddr == `TSP_OFF_LATCH))
            port_latch_r <= pwdata[2:0];
    end

    // Wait control and clock counter
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            xfer_r <= TSP_WAIT;
            clk_count_r <= 4'h0;
        end
        else if (watchdog_stack_reset | port_reset | (ctrl_wr & ~pwdata[`TSP_CTRL_TS]))
        begin
            xfer_r <= TSP_WAIT;
            clk_count_r <= 4'h0;
        end
        else
        begin
            case (xfer_r)
                TSP_WAIT:
                begin
                    if (ctrl_wr & pwdata[`TSP_CTRL_TS])
                    begin
                        xfer_r <= TSP_RUN;
                        clk_count_r <= 4'h0;
                    end
                end
                TSP_RUN:
                begin
                    if (ck_rise)
                        clk_count_r <= clk_count_r + 4'h1;
                    if (last_rise)
                        xfer_r <= TSP_WAIT;
                end
                default:
                    xfer_r <= TSP_WAIT;
            endcase
        end
    end

    // Shift register: MSB out on falls, LSB in on rises, load by software
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            serial_shift_register_r <= 8'h0;
            so_bit_r <= 1'b0;
        end
        else
        begin
            if (wr_acc & (paddr == `TSP_OFF_DATA))
                serial_shift_register_r <= pwdata[7:0];
            else if (running & ck_rise)
                serial_shift_register_r <= {serial_shift_register_r[6:0], si_sync_r[1]};
            if (running & ck_fall & serial_output_enable_r)
                so_bit_r <= serial_shift_register_r[7];
        end
    end

    // Internal shift clock generator, idles high, frozen by halt
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            gen_clk_r <= 1'b1;
            div_r <= 16'h0;
        end
        else if (!running || !master)
        begin
            gen_clk_r <= 1'b1;
            div_r <= 16'h0;
        end
        else if (!halt)
        begin
            if (div_r >= div_last)
            begin
                div_r <= 16'h0;
                gen_clk_r <= ~gen_clk_r;
            end
            else
                div_r <= div_r + 16'h1;
        end
    end

    // Pin drivers follow mode, direction and enable, unaffected by halt
    always_comb
    begin
        shift_clock_pin_oe = pin_dir_r[`TSP_PIN_CK];
        if (master)
            shift_clock_pin_out = gen_clk_r;
        else
            shift_clock_pin_out = port_latch_r[`TSP_PIN_CK];
        serial_out_pin_oe = pin_dir_r[`TSP_PIN_SO];
        if (serial_output_enable_r)
            serial_out_pin_out = so_bit_r;
        else
            serial_out_pin_out = port_latch_r[`TSP_PIN_SO];
        serial_in_pin_oe = pin_dir_r[`TSP_PIN_SI];
        serial_in_pin_out = port_latch_r[`TSP_PIN_SI];
    end

    // Sticky status; only a read that returned the bit clears it, set wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_stat_r <= 1'b0;
            irq_mask_r <= `TSP_MASK_RST;
        end
        else
        begin
            if (last_rise)
                irq_stat_r <= 1'b1;
            else if (rd_acc & (paddr == `TSP_OFF_STAT) & prdata_r[0])
                irq_stat_r <= 1'b0;
            if (wr_acc & (paddr == `TSP_OFF_MASK))
                irq_mask_r <= pwdata[0];
        end
    end
    assign irq = irq_stat_r & irq_mask_r;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence rise_running_s;
        running && ck_rise && !ctrl_wr && !watchdog_stack_reset && !port_reset;
    endsequence

    slave_pin_latch_a: assert property (
        !master |-> shift_clock_pin_out == port_latch_r[`TSP_PIN_CK])
        else $error("slave clock pin not from latch");
    si_float_a: assert property (
        !pin_dir_r[`TSP_PIN_SI] |-> !serial_in_pin_oe)
        else $error("serial in driven while input");
    si_drive_a: assert property (
        pin_dir_r[`TSP_PIN_SI] |-> serial_in_pin_oe
        && serial_in_pin_out == port_latch_r[`TSP_PIN_SI])
        else $error("serial in not driving latch");
    so_latch_a: assert property (
        !serial_output_enable_r |-> serial_out_pin_out == port_latch_r[`TSP_PIN_SO]
        && serial_out_pin_oe == pin_dir_r[`TSP_PIN_SO])
        else $error("serial out latch path wrong");
    count_step_a: assert property (
        rise_running_s |=> clk_count_r == $past(clk_count_r) + 4'h1)
        else $error("clock counter missed an edge");
    msb_out_a: assert property (
        running && ck_fall && serial_output_enable_r
        |=> serial_out_pin_out == $past(serial_shift_register_r[7]))
        else $error("MSB not shifted out");
    lsb_in_a: assert property (
        (rise_running_s and !wr_acc) |=> serial_shift_register_r[0] == $past(si_sync_r[1]))
        else $error("serial in not sampled into LSB");
    wdt_inputs_a: assert property (
        watchdog_stack_reset |=> pin_dir_r == 3'h0 && !master)
        else $error("watchdog reset left an output");
    ce_keep_dir_a: assert property (
        port_reset && !watchdog_stack_reset |=> $stable(pin_dir_r) && !running)
        else $error("chip enable reset changed directions");
    halt_freeze_a: assert property (
        halt && running && master && !ctrl_wr && !port_reset && !watchdog_stack_reset
        |=> $stable(gen_clk_r))
        else $error("internal clock ran during halt");
    eighth_wait_a: assert property (
        (rise_running_s and (clk_count_r == 4'h7))
        |=> !running && clk_count_r == 4'h8 && irq_stat_r)
        else $error("no wait or interrupt after eight clocks");
    force_wait_a: assert property (
        ctrl_wr && !pwdata[`TSP_CTRL_TS] |=> !running && clk_count_r == 4'h0)
        else $error("forced wait not taken");
    idle_high_a: assert property (
        master && !running |-> ##1 (shift_clock_pin_out || running))
        else $error("master clock not high in wait");

endmodule : tsp_serial_port
